// ---- src/trace_buffer_pkg.sv ----
package trace_buffer_pkg;

    localparam int          LINE_COUNT     = 64;
    localparam int          PTR_W          = 6;
    localparam int          DLY_W          = 6;
    localparam logic        FILTER_SUPPORT = 1'b1;

    // register offsets inside the 128 KiB window
    localparam logic [16:0] OFS_CONTROL    = 17'h00000;
    localparam logic [16:0] OFS_LINE_PTR   = 17'h00004;
    localparam logic [16:0] OFS_TIME_TAG   = 17'h00008;
    localparam logic [16:0] OFS_EXCLUDE    = 17'h0000C;
    localparam logic [16:0] OFS_BP1_ADDR   = 17'h00010;
    localparam logic [16:0] OFS_BP1_MASK   = 17'h00014;
    localparam logic [16:0] OFS_BP2_ADDR   = 17'h00018;
    localparam logic [16:0] OFS_BP2_MASK   = 17'h0001C;
    localparam int          MEM_WIN_BIT    = 16;
    localparam int          LINE_LSB       = 4;
    localparam int          WORD_LSB       = 2;

    // field positions
    localparam int          CTL_DLY_LSB    = 16;
    localparam int          CTL_RANGE_BIT  = 4;
    localparam int          CTL_SKIP_RD    = 3;
    localparam int          CTL_SKIP_WR    = 2;
    localparam int          CTL_DMODE_BIT  = 1;
    localparam int          CTL_EN_BIT     = 0;
    localparam int          BP_LOAD_BIT    = 1;
    localparam int          BP_STORE_BIT   = 0;
    localparam int          TRANS_ACT_BIT  = 1;
    localparam logic [31:0] BP_ADDR_KEEP   = 32'hFFFFFFFC;

    // reset values
    localparam logic [31:0] WORD_RST       = 32'h00000000;
    localparam logic [5:0]  PTR_RST        = 6'h00;
    localparam logic [5:0]  DLY_RST        = 6'h00;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [2:0]  hburst;
        logic [3:0]  hmaster;
        logic        hmastlock;
        logic        hready;
        logic [1:0]  hresp;
        logic [31:0] hrdata;
        logic [31:0] hwdata;
        logic [15:0] hsel;
        logic [15:1] hirq;
    } snoop_bus_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic        hready;
        logic [31:0] hwdata;
    } dbg_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic [1:0]  trans;
        logic [2:0]  size;
        logic [2:0]  burst;
        logic [3:0]  master;
        logic        lock;
    } addr_phase_t;

    typedef struct packed {
        logic [31:0] tag;
        logic        bp_hit;
        logic [15:1] hirq;
        logic        hwrite;
        logic [1:0]  htrans;
        logic [2:0]  hsize;
        logic [2:0]  hburst;
        logic [3:0]  hmaster;
        logic        hmastlock;
        logic [1:0]  hresp;
        logic [31:0] data;
        logic [31:0] addr;
    } trace_line_t;

    typedef enum logic [1:0] {
        SL_IDLE = 2'b01,
        SL_WAIT = 2'b10
    } slave_state_t;

endpackage

// ---- src/trace_line_store.sv ----
`timescale 1ns/1ps
module trace_line_store
    import trace_buffer_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        wr_en,
    input  wire logic [5:0]  wr_addr,
    input  wire trace_line_t wr_line,
    input  wire logic [5:0]  rd_addr,
    output trace_line_t      rd_line
);

    trace_line_t mem [LINE_COUNT];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_line;
        end
        rd_line <= mem[rd_addr];
    end

endmodule

// ---- src/ahb_bus_trace_buffer.sv ----
`timescale 1ns/1ps
// Overview of operation
// - decode 128 KiB window; control, pointer, tag, filter, two breakpoint pairs
// - trace memory at 0x10000 up, four words per line, high word first
// - control bits 31:16 hold freeze delay count, six bits implemented
// - control bit 4 keeps only transfers matching breakpoint two range
// - control bit 3 drops read transfers
// - control bit 2 drops write transfers
// - control bit 1 shows delay mode after a breakpoint hit
// - control bit 0 enables tracing; when clear nothing stored, tag frozen
// - pointer register shows next line in bits 9:4, low bits zero
// - 32-bit time tag counts each clock while enabled, stored per line
// - exclusion filter writable only when filtering is built in
// - filter bits 31:16 drop transfers to marked slaves
// - filter bits 15:0 drop transfers from marked masters
// - breakpoint hit stops tracing by clearing enable
// - nonzero delay: count down per line, then two more lines, then stop
// - breakpoint compares only address bits whose mask bit is one
// - breakpoint address holds bits 31:2, bits 1:0 read zero
// - mask bit 1 arms loads, bit 0 arms stores; neither never fires
// - line layout: tag, hit flag, irqs, controls, data, address
// - store at pointer then advance, wrapping circularly
// - breakpoint hit raises interrupt
module ahb_bus_trace_buffer
    import trace_buffer_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       debug_bus_gate,
    input  wire dbg_req_t   dbg_req,
    output logic            dbg_hreadyout,
    output logic [31:0]     dbg_hrdata,
    output logic [1:0]      dbg_hresp,
    input  wire snoop_bus_t snoop,
    output logic            bp_irq
);

    function automatic logic addr_match(input logic [31:0] a, input logic [31:0] ba,
                                        input logic [31:0] bm);
        addr_match = (((a ^ ba) & bm & BP_ADDR_KEEP) == 32'h00000000);
    endfunction

    function automatic logic bp_fire(input logic [31:0] a, input logic wr,
                                     input logic [31:0] ba, input logic [31:0] bm);
        bp_fire = addr_match(a, ba, bm) && (wr ? bm[BP_STORE_BIT] : bm[BP_LOAD_BIT]);
    endfunction

    // debug bus slave
    slave_state_t state_reg, state_next;
    logic [16:0]  sa_reg, sa_next;
    logic         swr_reg, swr_next;
    logic         hready_reg, hready_next;
    logic [31:0]  rdata_reg, rdata_next;
    logic         accept;
    logic         wr_fire;
    logic [31:0]  read_word;
    trace_line_t  mem_rd;

    // trace state
    logic              en_reg, en_next;
    logic              dmode_reg, dmode_next;
    logic              range_reg, range_next;
    logic              skip_rd_reg, skip_rd_next;
    logic              skip_wr_reg, skip_wr_next;
    logic [DLY_W-1:0]  dly_reg, dly_next;
    logic              tail_reg, tail_next;
    logic [PTR_W-1:0]  ptr_reg, ptr_next;
    logic [31:0]       tag_reg, tag_next;
    logic [31:0]       excl_reg, excl_next;
    logic [31:0]       bp1a_reg, bp1a_next;
    logic [31:0]       bp1m_reg, bp1m_next;
    logic [31:0]       bp2a_reg, bp2a_next;
    logic [31:0]       bp2m_reg, bp2m_next;
    logic              irq_reg, irq_next;
    addr_phase_t       ap_reg, ap_next;
    logic              apv_reg, apv_next;
    logic              aphit_reg, aphit_next;
    logic              apkeep_reg, apkeep_next;
    logic              done;
    logic              rec_fire;
    logic              hit_ev;
    logic              ctrl_wr;
    logic              tag_wr;
    trace_line_t       line;

    assign accept  = dbg_req.hsel && dbg_req.hready && dbg_req.htrans[TRANS_ACT_BIT]
                     && debug_bus_gate;
    assign wr_fire = (state_reg == SL_WAIT) && swr_reg;
    assign ctrl_wr = wr_fire && !sa_reg[MEM_WIN_BIT] && (sa_reg == OFS_CONTROL);
    assign tag_wr  = wr_fire && !sa_reg[MEM_WIN_BIT] && (sa_reg == OFS_TIME_TAG);

    always_comb begin
        read_word = 32'h00000000;
        if (sa_reg[MEM_WIN_BIT]) begin
            unique case (sa_reg[3:WORD_LSB])
                2'h0: read_word = mem_rd[127:96];
                2'h1: read_word = mem_rd[95:64];
                2'h2: read_word = mem_rd[63:32];
                2'h3: read_word = mem_rd[31:0];
            endcase
        end else begin
            case (sa_reg)
                OFS_CONTROL:  read_word = {10'h000, dly_reg, 11'h000, range_reg,
                                           skip_rd_reg, skip_wr_reg, dmode_reg, en_reg};
                OFS_LINE_PTR: read_word = {22'h000000, ptr_reg, 4'h0};
                OFS_TIME_TAG: read_word = tag_reg;
                OFS_EXCLUDE:  read_word = excl_reg;
                OFS_BP1_ADDR: read_word = bp1a_reg;
                OFS_BP1_MASK: read_word = bp1m_reg;
                OFS_BP2_ADDR: read_word = bp2a_reg;
                OFS_BP2_MASK: read_word = bp2m_reg;
                default:      read_word = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        state_next  = state_reg;
        sa_next     = sa_reg;
        swr_next    = swr_reg;
        hready_next = 1'b1;
        rdata_next  = rdata_reg;
        unique case (state_reg)
            SL_IDLE: begin
                if (accept) begin
                    state_next  = SL_WAIT;
                    sa_next     = dbg_req.haddr[16:0];
                    swr_next    = dbg_req.hwrite;
                    hready_next = 1'b0;
                end
            end
            SL_WAIT: begin
                state_next = SL_IDLE;
                rdata_next = swr_reg ? 32'h00000000 : read_word;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg  <= SL_IDLE;
            sa_reg     <= 17'h00000;
            swr_reg    <= 1'b0;
            hready_reg <= 1'b1;
            rdata_reg  <= WORD_RST;
        end else begin
            state_reg  <= state_next;
            sa_reg     <= sa_next;
            swr_reg    <= swr_next;
            hready_reg <= hready_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign dbg_hreadyout = hready_reg;
    assign dbg_hrdata    = rdata_reg;
    assign dbg_hresp     = 2'h0;
    assign bp_irq        = irq_reg;

    // snooped transfer completes when its data phase sees hready
    assign done     = apv_reg && snoop.hready;
    assign rec_fire = done && apkeep_reg && en_reg;
    assign hit_ev   = done && aphit_reg && en_reg;

    always_comb begin
        line.tag       = tag_reg;
        line.bp_hit    = aphit_reg;
        line.hirq      = snoop.hirq;
        line.hwrite    = ap_reg.write;
        line.htrans    = ap_reg.trans;
        line.hsize     = ap_reg.size;
        line.hburst    = ap_reg.burst;
        line.hmaster   = ap_reg.master;
        line.hmastlock = ap_reg.lock;
        line.hresp     = snoop.hresp;
        line.data      = ap_reg.write ? snoop.hwdata : snoop.hrdata;
        line.addr      = ap_reg.addr;
    end

    always_comb begin
        ap_next.addr   = snoop.haddr;
        ap_next.write  = snoop.hwrite;
        ap_next.trans  = snoop.htrans;
        ap_next.size   = snoop.hsize;
        ap_next.burst  = snoop.hburst;
        ap_next.master = snoop.hmaster;
        ap_next.lock   = snoop.hmastlock;
        apv_next       = apv_reg;
        aphit_next     = aphit_reg;
        apkeep_next    = apkeep_reg;
        if (snoop.hready) begin
            apv_next    = snoop.htrans[TRANS_ACT_BIT];
            aphit_next  = bp_fire(snoop.haddr, snoop.hwrite, bp1a_reg, bp1m_reg)
                          || bp_fire(snoop.haddr, snoop.hwrite, bp2a_reg, bp2m_reg);
            apkeep_next = !(skip_rd_reg && !snoop.hwrite)
                          && !(skip_wr_reg && snoop.hwrite)
                          && !(range_reg && !addr_match(snoop.haddr, bp2a_reg, bp2m_reg))
                          && !excl_reg[snoop.hmaster]
                          && ((excl_reg[31:16] & snoop.hsel) == 16'h0000);
        end else begin
            ap_next = ap_reg;
        end
    end

    always_comb begin
        en_next      = en_reg;
        dmode_next   = dmode_reg;
        range_next   = range_reg;
        skip_rd_next = skip_rd_reg;
        skip_wr_next = skip_wr_reg;
        dly_next     = dly_reg;
        tail_next    = tail_reg;
        ptr_next     = ptr_reg;
        tag_next     = tag_reg;
        excl_next    = excl_reg;
        bp1a_next    = bp1a_reg;
        bp1m_next    = bp1m_reg;
        bp2a_next    = bp2a_reg;
        bp2m_next    = bp2m_reg;
        irq_next     = 1'b0;
        if (ctrl_wr) begin
            dly_next     = dly_field(dbg_req.hwdata);
            range_next   = dbg_req.hwdata[CTL_RANGE_BIT] & FILTER_SUPPORT;
            skip_rd_next = dbg_req.hwdata[CTL_SKIP_RD] & FILTER_SUPPORT;
            skip_wr_next = dbg_req.hwdata[CTL_SKIP_WR] & FILTER_SUPPORT;
            dmode_next   = dbg_req.hwdata[CTL_DMODE_BIT];
            en_next      = dbg_req.hwdata[CTL_EN_BIT];
            tail_next    = 1'b0;
        end
        if (wr_fire && !sa_reg[MEM_WIN_BIT]) begin
            case (sa_reg)
                OFS_LINE_PTR: ptr_next  = dbg_req.hwdata[LINE_LSB +: PTR_W];
                OFS_EXCLUDE:  excl_next = FILTER_SUPPORT ? dbg_req.hwdata : excl_reg;
                OFS_BP1_ADDR: bp1a_next = dbg_req.hwdata & BP_ADDR_KEEP;
                OFS_BP1_MASK: bp1m_next = dbg_req.hwdata;
                OFS_BP2_ADDR: bp2a_next = dbg_req.hwdata & BP_ADDR_KEEP;
                OFS_BP2_MASK: bp2m_next = dbg_req.hwdata;
                default:      ;
            endcase
        end
        if (tag_wr) begin
            tag_next = dbg_req.hwdata;
        end else if (en_reg) begin
            tag_next = tag_reg + 32'h00000001;
        end
        if (rec_fire) begin
            ptr_next = ptr_reg + 6'h01;
        end
        if (rec_fire && dmode_reg) begin
            if (dly_reg != DLY_RST) begin
                dly_next = dly_reg - 6'h01;
            end else if (tail_reg) begin
                en_next    = 1'b0;
                dmode_next = 1'b0;
                tail_next  = 1'b0;
            end else begin
                tail_next = 1'b1;
            end
        end
        if (hit_ev) begin
            irq_next = 1'b1;
            if (!dmode_reg) begin
                if (dly_reg == DLY_RST) begin
                    en_next = 1'b0;
                end else begin
                    dmode_next = 1'b1;
                    tail_next  = 1'b0;
                end
            end
        end
    end

    function automatic logic [DLY_W-1:0] dly_field(input logic [31:0] w);
        dly_field = w[CTL_DLY_LSB +: DLY_W];
    endfunction

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_reg      <= 1'b0;
            dmode_reg   <= 1'b0;
            range_reg   <= 1'b0;
            skip_rd_reg <= 1'b0;
            skip_wr_reg <= 1'b0;
            dly_reg     <= DLY_RST;
            tail_reg    <= 1'b0;
            ptr_reg     <= PTR_RST;
            tag_reg     <= WORD_RST;
            excl_reg    <= WORD_RST;
            bp1a_reg    <= WORD_RST;
            bp1m_reg    <= WORD_RST;
            bp2a_reg    <= WORD_RST;
            bp2m_reg    <= WORD_RST;
            irq_reg     <= 1'b0;
            ap_reg      <= '0;
            apv_reg     <= 1'b0;
            aphit_reg   <= 1'b0;
            apkeep_reg  <= 1'b0;
        end else begin
            en_reg      <= en_next;
            dmode_reg   <= dmode_next;
            range_reg   <= range_next;
            skip_rd_reg <= skip_rd_next;
            skip_wr_reg <= skip_wr_next;
            dly_reg     <= dly_next;
            tail_reg    <= tail_next;
            ptr_reg     <= ptr_next;
            tag_reg     <= tag_next;
            excl_reg    <= excl_next;
            bp1a_reg    <= bp1a_next;
            bp1m_reg    <= bp1m_next;
            bp2a_reg    <= bp2a_next;
            bp2m_reg    <= bp2m_next;
            irq_reg     <= irq_next;
            ap_reg      <= ap_next;
            apv_reg     <= apv_next;
            aphit_reg   <= aphit_next;
            apkeep_reg  <= apkeep_next;
        end
    end

    trace_line_store u_store (
        .clock   (clock),
        .wr_en   (rec_fire),
        .wr_addr (ptr_reg),
        .wr_line (line),
        .rd_addr (dbg_req.haddr[LINE_LSB +: PTR_W]),
        .rd_line (mem_rd)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_accept;
        (state_reg == SL_IDLE) && accept;
    endsequence

    sequence s_answer;
        !dbg_hreadyout ##1 dbg_hreadyout;
    endsequence

    AST_READ_WAIT: assert property (s_accept |=> s_answer)
        else $error("slave answer not after one wait state");
    AST_TAG_FROZEN: assert property (!en_reg && !tag_wr |=> $stable(tag_reg))
        else $error("time tag moved while tracing disabled");
    AST_TAG_COUNT: assert property (en_reg && !tag_wr |=> tag_reg == $past(tag_reg) + 32'h1)
        else $error("time tag did not count by one");
    AST_PTR_ADVANCE: assert property (rec_fire |=> ptr_reg == $past(ptr_reg) + 6'h01)
        else $error("line pointer did not advance after a stored line");
    AST_NO_REC_OFF: assert property (!en_reg && !wr_fire |=> $stable(ptr_reg))
        else $error("line stored while tracing disabled");
    AST_HIT_IRQ: assert property (hit_ev |=> bp_irq ##1 !bp_irq)
        else $error("breakpoint interrupt not a single pulse");
    AST_FREEZE_NOW: assert property (hit_ev && !dmode_reg && dly_reg == 6'h00 && !ctrl_wr
                                     |=> !en_reg)
        else $error("tracing not stopped on breakpoint hit");
    AST_DELAY_ENTER: assert property (hit_ev && !dmode_reg && dly_reg != 6'h00 && !ctrl_wr
                                      |=> dmode_reg && en_reg)
        else $error("delay mode not entered on hit with nonzero count");
    AST_SKIP_READS: assert property (rec_fire |-> !(skip_rd_reg && !ap_reg.write) || !apkeep_reg)
        else $error("read stored while reads are skipped");

endmodule

// ---- dv/snoop_bus_model.sv ----
`timescale 1ns/1ps
module snoop_bus_model
    import trace_buffer_pkg::*;
(
    input  wire logic clock,
    output snoop_bus_t snoop
);
    initial begin
        snoop = '0;
        snoop.hready = 1'b1;
    end

    // address phase, data phase, then ws wait states before completion
    task automatic xfer(input logic [31:0] a, input logic w, input logic [3:0] m,
                        input int s, input logic [31:0] d, input logic [15:1] irq,
                        input logic [2:0] sz, input int ws);
        @(posedge clock);
        #1;
        snoop.haddr = a;
        snoop.htrans = 2'b10;
        snoop.hwrite = w;
        snoop.hsize = sz;
        snoop.hburst = 3'h0;
        snoop.hmaster = m;
        snoop.hmastlock = 1'b0;
        snoop.hsel = 16'h0001 << s;
        @(posedge clock);
        #1;
        snoop.htrans = 2'b00;
        snoop.haddr = ~a;
        snoop.hsel = 16'h0000;
        snoop.hresp = 2'h0;
        snoop.hwdata = w ? d : ~d;
        snoop.hrdata = w ? ~d : d;
        snoop.hirq = irq;
        if (ws > 0) begin
            snoop.hready = 1'b0;
            repeat (ws) @(posedge clock);
            #1;
            snoop.hready = 1'b1;
        end
    endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb
    import trace_buffer_pkg::*;
;
    logic        clock;
    logic        sys_rst;
    logic        debug_bus_gate;
    dbg_req_t    dbg_req;
    logic        dbg_hreadyout;
    logic [31:0] dbg_hrdata;
    logic [1:0]  dbg_hresp;
    snoop_bus_t  snoop;
    logic        bp_irq;
    int          num_errors;
    int          n_compared;
    int          cycles;
    int          irq_seen;
    // bench model state
    bit          en_m, dmode_m, rng_m, skr_m, skw_m;
    bit [5:0]    dly_m;
    bit [31:0]   excl_m;
    bit [31:0]   ba_m [2];
    bit [31:0]   bm_m [2];
    trace_line_t mem_m [64];
    int          stamp_m [64];
    int          ptr_m, extra_m, hits_m, tnow;

    ahb_bus_trace_buffer dut (.clock(clock), .sys_rst(sys_rst), .debug_bus_gate(debug_bus_gate),
        .dbg_req(dbg_req), .dbg_hreadyout(dbg_hreadyout), .dbg_hrdata(dbg_hrdata),
        .dbg_hresp(dbg_hresp), .snoop(snoop), .bp_irq(bp_irq));
    snoop_bus_model bus (.clock(clock), .snoop(snoop));

    always #10 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (bp_irq === 1'b1) irq_seen++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic cyc(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clock);
        #1;
        dbg_req.hsel = 1'b1;
        dbg_req.haddr = a;
        dbg_req.htrans = 2'b10;
        dbg_req.hwrite = w;
        @(posedge clock);
        #1;
        dbg_req.hsel = 1'b0;
        dbg_req.htrans = 2'b00;
        dbg_req.hwdata = wd;
        n = 0;
        while (dbg_hreadyout !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("dbg_ready_hresp", 32'h0, {29'h0, n == 8, dbg_hresp});
        rd = dbg_hrdata;
    endtask

    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] g;
        cyc(a, 1'b0, 32'h0, g);
        chk(nm, e, g);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        cyc(a, 1'b1, d, x);
        if (debug_bus_gate === 1'b1) begin
            case (a)
                32'h0: {dly_m, rng_m, skr_m, skw_m, dmode_m, en_m} = {d[21:16], d[4:0]};
                32'hC: excl_m = d;
                32'h10, 32'h18: ba_m[a[3]] = d & BP_ADDR_KEEP;
                32'h14, 32'h1C: bm_m[a[3]] = d;
                default: ;
            endcase
        end
    endtask

    function automatic logic [31:0] ctl_m();
        return {10'h000, dly_m, 11'h000, rng_m, skr_m, skw_m, dmode_m, en_m};
    endfunction

    task automatic op(input logic [31:0] a, input logic w, input int m, input int s);
        logic [31:0] d;
        logic [15:1] irq;
        logic [2:0]  sz;
        int          ws;
        bit          hit, keep;
        d = $urandom();
        irq = 15'($urandom());
        sz = 3'($urandom_range(2, 0));
        ws = $urandom_range(2, 0);
        bus.xfer(a, w, 4'(m), s, d, irq, sz, ws);
        tnow += 2 + ws;
        if (en_m) begin
            hit = 0;
            for (int k = 0; k < 2; k++)
                if (bm_m[k][w ? 0 : 1] && ((a ^ ba_m[k]) & bm_m[k] & BP_ADDR_KEEP) == 0) hit = 1;
            keep = !(w ? skw_m : skr_m) && !excl_m[m] && !excl_m[16 + s]
                   && (!rng_m || ((a ^ ba_m[1]) & bm_m[1] & BP_ADDR_KEEP) == 0);
            if (keep) begin
                mem_m[ptr_m % 64] = '{tag: 32'h0, bp_hit: hit, hirq: irq, hwrite: w,
                    htrans: 2'b10, hsize: sz, hburst: 3'h0, hmaster: 4'(m),
                    hmastlock: 1'b0, hresp: 2'h0, data: d, addr: a};
                stamp_m[ptr_m % 64] = tnow;
                ptr_m++;
            end
            hits_m += int'(hit);
            if (hit && !dmode_m) begin
                if (dly_m == 0) en_m = 0;
                else dmode_m = 1;
            end else if (dmode_m && keep) begin
                if (dly_m != 0) dly_m--;
                else extra_m++;
                if (extra_m == 2) begin
                    en_m = 0;
                    dmode_m = 0;
                    extra_m = 0;
                end
            end
        end
    endtask

    task automatic line_chk(input int i, output logic [31:0] tag);
        logic [31:0] w [4];
        for (int k = 0; k < 4; k++) cyc(32'(32'h10000 + i * 16 + k * 4), 1'b0, 32'h0, w[k]);
        chk("line_flags", mem_m[i][95:64], w[1]);
        chk("line_data", mem_m[i][63:32], w[2]);
        chk("line_addr", mem_m[i][31:0], w[3]);
        tag = w[0];
    endtask

    task automatic rnd_ops(input int cnt, input logic [3:0] top);
        repeat (cnt) op({top | 4'($urandom_range(1, 0)), 28'($urandom())}, 1'($urandom()),
                        $urandom_range(7, 0), $urandom_range(7, 0));
    endtask

    initial begin
        logic [31:0] t, tp;
        int          j, pj, hp;
        clock = 0;
        sys_rst = 1;
        debug_bus_gate = 1;
        dbg_req = '0;
        dbg_req.hready = 1'b1;
        void'($urandom(32'h047D12BB));
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 0;
        for (int k = 0; k < 9; k++) rchk("reset_reg", 32'(k * 4), 32'h0);
        $display("test reset done");
        wr(32'h0, 32'hFFFFFFFE);
        rchk("control", 32'h0, ctl_m());
        wr(32'h0, 32'h0);
        for (int k = 3; k < 8; k++) begin
            t = $urandom();
            wr(32'(k * 4), t);
            rchk("reg_rw", 32'(k * 4), (k == 4 || k == 6) ? t & BP_ADDR_KEEP : t);
            wr(32'(k * 4), 32'h0);
        end
        wr(32'h8, 32'h12345678);
        rchk("tag_frozen", 32'h8, 32'h12345678);
        rchk("tag_frozen", 32'h8, 32'h12345678);
        debug_bus_gate = 0;
        wr(32'hC, 32'hA5A50F0F);
        debug_bus_gate = 1;
        rchk("gated_write", 32'hC, excl_m);
        $display("test registers done");
        wr(32'h0, 32'h1);
        rnd_ops(70, 4'h0);
        wr(32'h0, 32'h0);
        rchk("line_ptr", 32'h4, 32'(ptr_m % 64) << 4);
        for (int i = 8; i >= 1; i--) begin
            j = (ptr_m - i + 64) % 64;
            line_chk(j, t);
            if (i < 8) chk("tag_step", 32'(stamp_m[j] - stamp_m[pj]), t - tp);
            tp = t;
            pj = j;
        end
        $display("test trace done");
        wr(32'h18, 32'h40000000);
        wr(32'h1C, 32'hF0000000);
        for (int md = 0; md < 5; md++) begin
            wr(32'hC, md == 2 ? 32'h00000008 : md == 3 ? 32'h00200000 : 32'h0);
            wr(32'h0, md == 0 ? 32'h5 : md == 1 ? 32'h9 : md == 4 ? 32'h11 : 32'h1);
            rnd_ops(8, 4'h4);
            wr(32'h0, 32'h0);
            rchk("filter_ptr", 32'h4, 32'(ptr_m % 64) << 4);
            line_chk((ptr_m + 63) % 64, t);
        end
        $display("test filters done");
        wr(32'h18, 32'h0);
        wr(32'h1C, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr(32'(32'h10 + k * 8), 32'h80001000);
            wr(32'(32'h14 + k * 8), 32'hFFFFF000 | 32'(k == 0 ? 1 : 2));
            wr(32'h0, k == 1 ? 32'h00030001 : 32'h1);
            op(32'h80001010, 1'(k), 1, 1);
            op(32'h20000000, 1'(k == 0), 1, 1);
            hp = ptr_m % 64;
            op(32'h80001234, 1'(k == 0), 2, 2);
            rchk("control_hit", 32'h0, ctl_m());
            rnd_ops(8, 4'h2);
            rchk("control_end", 32'h0, ctl_m());
            rchk("bp_ptr", 32'h4, 32'(ptr_m % 64) << 4);
            line_chk(hp, t);
            wr(32'(32'h14 + k * 8), 32'h0);
        end
        chk("irq_count", 32'(hits_m), 32'(irq_seen));
        $display("test breakpoints done");
        tally_and_finish();
    end
endmodule
